/* File: rtl/serial_port_pkg.sv */
// Shared constants for the serial port configuration and pin block.
// Assumes a 32-bit AHB-Lite register slave with word-aligned registers.
package serial_port_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTL1 = 8'h00;
    localparam logic [7:0] OFS_CTL2 = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_DATA = 8'h0c;
    localparam logic [7:0] OFS_IRDA = 8'h10;
    localparam logic [7:0] OFS_BRKC = 8'h14;
    // serial_control_one fields
    localparam int B_LOOP = 7;
    localparam int B_ON = 6;
    localparam int B_LEN9 = 4;
    localparam int B_WAKE = 3;
    localparam int B_IDLE = 2;
    localparam int B_PAR = 1;
    localparam int B_SENSE = 0;
    // serial_control_two fields
    localparam int B_TXON = 3;
    localparam int B_RXON = 2;
    localparam int B_STBY = 1;
    // serial_status_one fields
    localparam int B_TXE = 7;
    localparam int B_TXD = 6;
    localparam int B_RXF = 5;
    localparam int B_IDL = 4;
    localparam int B_FE = 1;
    localparam int B_PE = 0;
    // Reset values
    localparam logic [7:0] CTL1_RST = 8'h00;
    // Frame lengths in bit times, start and stop included
    localparam logic [3:0] FRAME_LEN8 = 4'ha;
    localparam logic [3:0] FRAME_LEN9 = 4'hb;
    // Infrared zero pulse is this fraction of a bit time
    localparam int IR_NUM = 3;
    localparam int IR_DEN = 16;
    typedef enum logic {TX_IDLE = 1'b0, TX_BUSY = 1'b1} tx_state_t;
    typedef enum logic {RX_IDLE = 1'b0, RX_BITS = 1'b1} rx_state_t;
endpackage

/* File: rtl/serial_tx_shift.sv */
// Transmit shifter: sends a prepared frame LSB first, one bit per bit time.
// Assumes the caller builds start, data, parity and stop bits.
`timescale 1ns/1ps
module serial_tx_shift
    import serial_port_pkg::*;
#(
    parameter int BIT_CLKS = 16
)
(
    input wire logic hclk, // Module clock
    input wire logic hresetn, // Async reset, active low
    input wire logic run, // Low freezes all state
    input wire logic load, // Take frame when idle
    input wire logic [10:0] frame, // Frame bits, LSB first
    input wire logic [3:0] nbits, // Bits in frame
    output logic line, // Serial level
    output logic busy, // Frame in flight
    output logic early // In first part of a bit
);
    tx_state_t state;
    logic [10:0] shreg;
    logic [3:0] left;
    logic [15:0] phase;

    // Frozen while run is low so stop mode keeps every bit in place
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state <= TX_IDLE;
            shreg <= 11'h7ff;
            left <= 4'h0;
            phase <= 16'h0000;
        end
        else if (run)
        begin
            unique case (state)
                TX_IDLE:
                begin
                    if (load)
                    begin
                        shreg <= frame;
                        left <= nbits;
                        phase <= 16'h0000;
                        state <= TX_BUSY;
                    end
                end
                TX_BUSY:
                begin
                    if (phase == 16'(BIT_CLKS - 1))
                    begin
                        phase <= 16'h0000;
                        shreg <= {1'b1, shreg[10:1]};
                        left <= left - 4'h1;
                        if (left == 4'h1)
                            state <= TX_IDLE;
                    end
                    else
                        phase <= phase + 16'h0001;
                end
            endcase
        end
    end

    // Line idles high through the all-ones reset value
    assign line = shreg[0];
    assign busy = (state == TX_BUSY);
    assign early = busy && (phase < 16'(BIT_CLKS * IR_NUM / IR_DEN));
endmodule // serial_tx_shift

/* File: rtl/serial_rx_shift.sv */
// Receive shifter: mid-bit sampling of start, data and stop bits, plus
// detection of an idle line as a frame's worth of ones.
// Assumes rx_in is already synchronous and held high when ignored.
`timescale 1ns/1ps
module serial_rx_shift
    import serial_port_pkg::*;
#(
    parameter int BIT_CLKS = 16
)
(
    input wire logic hclk, // Module clock
    input wire logic hresetn, // Async reset, active low
    input wire logic run, // Low freezes all state
    input wire logic rx_in, // Selected receive level
    input wire logic len9, // Nine-bit characters
    input wire logic origin, // Count ones after stop bit
    output logic done, // Character complete pulse
    output logic stop_bad, // Stop bit sampled low
    output logic idle_pulse, // Idle line found pulse
    output logic [8:0] word // Received character
);
    rx_state_t state;
    logic [15:0] phase;
    logic [15:0] iphase;
    logic [3:0] bitno;
    logic [3:0] ones;
    logic [8:0] shreg;
    logic idle_seen;
    logic [3:0] last;
    logic [3:0] flen;

    assign last = len9 ? 4'ha : 4'h9;
    assign flen = len9 ? FRAME_LEN9 : FRAME_LEN8;
    // Eight-bit characters end one place higher in the shifter
    assign word = len9 ? shreg : {1'b0, shreg[8:1]};

    // Character framing; a start bit high at mid-bit is treated as noise
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state <= RX_IDLE;
            phase <= 16'h0000;
            bitno <= 4'h0;
            shreg <= 9'h000;
            done <= 1'b0;
            stop_bad <= 1'b0;
        end
        else if (run)
        begin
            done <= 1'b0;
            unique case (state)
                RX_IDLE:
                begin
                    if (!rx_in)
                    begin
                        state <= RX_BITS;
                        phase <= 16'h0000;
                        bitno <= 4'h0;
                    end
                end
                RX_BITS:
                begin
                    phase <= (phase == 16'(BIT_CLKS - 1)) ? 16'h0000
                                                          : phase + 16'h0001;
                    if (phase == 16'(BIT_CLKS / 2))
                    begin
                        bitno <= bitno + 4'h1;
                        if (bitno == 4'h0 && rx_in)
                            state <= RX_IDLE;
                        else if (bitno == last)
                        begin
                            done <= 1'b1;
                            stop_bad <= !rx_in;
                            state <= RX_IDLE;
                        end
                        else if (bitno != 4'h0)
                            shreg <= {rx_in, shreg[8:1]};
                    end
                end
            endcase
        end
    end

    // Any zero restarts the count; with origin set, frames also hold it off
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            iphase <= 16'h0000;
            ones <= 4'h0;
            idle_seen <= 1'b0;
            idle_pulse <= 1'b0;
        end
        else if (run)
        begin
            idle_pulse <= 1'b0;
            if (!rx_in)
            begin
                iphase <= 16'h0000;
                ones <= 4'h0;
                idle_seen <= 1'b0;
            end
            else if (origin && state == RX_BITS)
            begin
                iphase <= 16'h0000;
                ones <= 4'h0;
            end
            else if (iphase == 16'(BIT_CLKS - 1))
            begin
                iphase <= 16'h0000;
                if (ones != flen)
                    ones <= ones + 4'h1;
                if (ones == flen - 4'h1 && !idle_seen)
                begin
                    idle_pulse <= 1'b1;
                    idle_seen <= 1'b1;
                end
            end
            else
                iphase <= iphase + 16'h0001;
        end
    end
endmodule // serial_rx_shift

/* File: rtl/serial_port_top.sv */
// Serial port configuration, status flags and pin control behind an
// AHB-Lite register slave. Assumes one master, single word transfers,
// and pin inputs already synchronous to hclk.
//
// The AHB-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps
// Functional notes
// - Stop mode freezes module, registers kept
// - Resume only after external wake interrupt
// - Clear allowed in break stays cleared
// - Break without permission protects all flags except done
// - Enabled: transmit output, receive input
// - Disabled: both pins follow port control
// - Transmit pin released after frame ends
// - Receive pin ignored unless receiver on
// - Loop routes transmitter into receiver directly
// - Disable sets empty and done flags
// - Length bit picks 9 or 8 bits
// - Wake bit picks address or idle
// - Idle count starts after stop or start
// - Parity sits in character top bit
// - Sense bit selects odd or even
// - One start, one stop bit framing
// - Reset clears all control one bits
// - Direction enables locked while module off
// - Framing error sets with receive full
module serial_port_top
    import serial_port_pkg::*;
#(
    parameter int BIT_CLKS = 16
)
(
    input wire logic hclk, // Module clock
    input wire logic hresetn, // Async reset, active low
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Word only
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    output logic hreadyout, // Slave ready
    output logic [31:0] hrdata, // Read data
    output logic hresp, // Always OKAY
    input wire logic stop_req, // Processor enters stop
    input wire logic wake_irq, // External wake interrupt
    input wire logic break_state, // Debug break active
    input wire logic port_dir_bit6, // Port direction, pin 6
    input wire logic port_dir_bit7, // Port direction, pin 7
    input wire logic port_out6, // Port data, pin 6
    input wire logic port_out7, // Port data, pin 7
    input wire logic serial_in_pin, // Receive pin level
    output logic serial_out_pin, // Transmit pin drive level
    output logic serial_out_oe, // Transmit pin pulls low
    output logic serial_in_drv, // Receive pin drive level
    output logic serial_in_oe // Receive pin pulls low
);
    logic [7:0] ctl1;
    logic tx_on, rx_on, standby, ir_on, allow, stopped;
    logic txe, txd, rxf, idl, fe, pe, arm_tx, arm_rx;
    logic tx_pend, pre_pend, wr_pend;
    logic [7:0] wr_addr;
    logic [8:0] tx_buf, rx_data;
    logic [15:0] ir_cnt;
    logic on, run, freeze, ap, ap_rd, len9, msb;
    logic tx_load, tx_line, tx_busy, tx_early, tx_val;
    logic rx_in, rx_done, rx_bad, rx_idle, wake_addr, wake_idle;
    logic wr_ctl2, wr_data, rd_stat, rd_data, port7_drive;
    logic [8:0] rx_word;
    logic [8:0] payload;
    logic [10:0] frame;
    logic [3:0] nbits;
    logic [31:0] next_rdata;

    assign on = ctl1[B_ON];
    assign run = on && !stopped;
    assign freeze = break_state && !allow;
    assign len9 = ctl1[B_LEN9];
    assign ap = hsel && htrans[1] && hready;
    assign ap_rd = ap && !hwrite;
    assign wr_ctl2 = wr_pend && wr_addr == OFS_CTL2;
    assign wr_data = wr_pend && wr_addr == OFS_DATA;
    assign rd_stat = ap_rd && haddr[7:0] == OFS_STAT;
    assign rd_data = ap_rd && haddr[7:0] == OFS_DATA;
    assign port7_drive = port_dir_bit7 && !port_out7;

    // Zero wait states; reads are registered from the address phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0000_0000;
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end
        else
        begin
            wr_pend <= ap && hwrite && haddr[31:8] == 24'h00_0000;
            wr_addr <= haddr[7:0];
            if (ap_rd)
                hrdata <= (haddr[31:8] == 24'h00_0000) ? next_rdata
                                                       : 32'h0000_0000;
        end
    end

    // Unmapped offsets read as zero
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        unique case (haddr[7:0])
            OFS_CTL1: next_rdata[7:0] = ctl1;
            OFS_CTL2: next_rdata[7:0] = {4'h0, tx_on, rx_on, standby, 1'b0};
            OFS_STAT: next_rdata[7:0] = {txe, txd, rxf, idl, 2'b00, fe, pe};
            OFS_DATA: next_rdata[8:0] = rx_data;
            OFS_IRDA: next_rdata[0] = ir_on;
            OFS_BRKC: next_rdata[0] = allow;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // Plain configuration registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctl1 <= CTL1_RST;
            ir_on <= 1'b0;
            allow <= 1'b0;
        end
        else if (wr_pend)
        begin
            if (wr_addr == OFS_CTL1)
                ctl1 <= hwdata[7:0];
            if (wr_addr == OFS_IRDA)
                ir_on <= hwdata[0];
            if (wr_addr == OFS_BRKC)
                allow <= hwdata[0];
        end
    end

    // Direction enables only take writes while the module is on
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tx_on <= 1'b0;
            rx_on <= 1'b0;
            standby <= 1'b0;
            pre_pend <= 1'b0;
        end
        else
        begin
            if (wr_ctl2 && on)
            begin
                tx_on <= hwdata[B_TXON];
                rx_on <= hwdata[B_RXON];
            end
            // A fresh enable queues a preamble of one idle frame
            if (wr_ctl2 && on && hwdata[B_TXON] && !tx_on)
                pre_pend <= 1'b1;
            else if (tx_load)
                pre_pend <= 1'b0;
            // Wakeup wins over a software write in the same cycle
            if (wake_addr || wake_idle)
                standby <= 1'b0;
            else if (wr_ctl2)
                standby <= hwdata[B_STBY];
        end
    end

    // Stop mode holds until an external interrupt wakes the processor
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            stopped <= 1'b0;
        else if (stopped && wake_irq)
            stopped <= 1'b0;
        else if (stop_req)
            stopped <= 1'b1;
    end

    // Parity replaces the top bit of the character
    always_comb
    begin
        payload = tx_buf;
        if (len9 && ctl1[B_PAR])
            payload[8] = ^tx_buf[7:0] ^ ctl1[B_SENSE];
        else if (!len9)
        begin
            payload[8] = 1'b1;
            if (ctl1[B_PAR])
                payload[7] = ^tx_buf[6:0] ^ ctl1[B_SENSE];
        end
        frame = pre_pend ? 11'h7ff : {1'b1, payload, 1'b0};
        nbits = len9 ? FRAME_LEN9 : FRAME_LEN8;
    end

    assign tx_load = run && tx_on && !tx_busy && (pre_pend || tx_pend);

    // Transmit buffer and empty flag; the shifter taking data sets it
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tx_buf <= 9'h000;
            tx_pend <= 1'b0;
            txe <= 1'b1;
            txd <= 1'b1;
            arm_tx <= 1'b0;
        end
        else
        begin
            if (wr_data)
            begin
                tx_buf <= hwdata[8:0];
                tx_pend <= 1'b1;
            end
            else if (tx_load && !pre_pend)
                tx_pend <= 1'b0;
            if (rd_stat && txe && !freeze)
                arm_tx <= 1'b1;
            else if (wr_data && arm_tx && !freeze)
                arm_tx <= 1'b0;
            if (!on || (tx_load && !pre_pend))
                txe <= 1'b1;
            else if (wr_data && arm_tx && !freeze)
                txe <= 1'b0;
            txd <= !on || !(tx_busy || tx_pend || pre_pend);
        end
    end

    serial_tx_shift #(
        .BIT_CLKS(BIT_CLKS)
    ) u_tx (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(run),
        .load(tx_load),
        .frame(frame),
        .nbits(nbits),
        .line(tx_line),
        .busy(tx_busy),
        .early(tx_early)
    );

    // Infrared input: a narrow low pulse stands for a whole zero bit
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ir_cnt <= 16'h0000;
        else if (!serial_in_pin)
            ir_cnt <= 16'(BIT_CLKS - 1);
        else if (ir_cnt != 16'h0000)
            ir_cnt <= ir_cnt - 16'h0001;
    end

    // Loop bypasses the infrared path; a disabled receiver sees idle
    always_comb
    begin
        if (!rx_on)
            rx_in = 1'b1;
        else if (ctl1[B_LOOP])
            rx_in = tx_line;
        else if (ir_on)
            rx_in = serial_in_pin && ir_cnt == 16'h0000;
        else
            rx_in = serial_in_pin;
    end

    serial_rx_shift #(
        .BIT_CLKS(BIT_CLKS)
    ) u_rx (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(run),
        .rx_in(rx_in),
        .len9(len9),
        .origin(ctl1[B_IDLE]),
        .done(rx_done),
        .stop_bad(rx_bad),
        .idle_pulse(rx_idle),
        .word(rx_word)
    );

    assign msb = len9 ? rx_word[8] : rx_word[7];
    assign wake_addr = rx_done && standby && ctl1[B_WAKE] && msb;
    assign wake_idle = rx_idle && standby && !ctl1[B_WAKE];

    // Receive flags: new events win over a clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rx_data <= 9'h000;
            rxf <= 1'b0;
            idl <= 1'b0;
            fe <= 1'b0;
            pe <= 1'b0;
            arm_rx <= 1'b0;
        end
        else
        begin
            if (rd_stat && (rxf || idl || fe || pe) && !freeze)
                arm_rx <= 1'b1;
            else if (rd_data && arm_rx && !freeze)
                arm_rx <= 1'b0;
            if (rx_done && (!standby || wake_addr))
            begin
                rx_data <= rx_word;
                rxf <= 1'b1;
                fe <= rx_bad;
                pe <= ctl1[B_PAR] && (^rx_word ^ ctl1[B_SENSE]);
            end
            else if (rd_data && arm_rx && !freeze)
            begin
                rxf <= 1'b0;
                fe <= 1'b0;
                pe <= 1'b0;
            end
            if (rx_idle && !standby)
                idl <= 1'b1;
            else if (rd_data && arm_rx && !freeze)
                idl <= 1'b0;
        end
    end

    // Infrared output pulls low only early in each zero bit
    assign tx_val = ir_on ? !(!tx_line && tx_early) : tx_line;

    // Both pins are open drain: the enable pulls the wire low
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            serial_out_pin <= 1'b0;
            serial_in_drv <= 1'b0;
            serial_out_oe <= 1'b0;
            serial_in_oe <= 1'b0;
        end
        else if (!on)
        begin
            serial_out_oe <= port_dir_bit6 && !port_out6;
            serial_in_oe <= port7_drive;
        end
        else
        begin
            serial_out_oe <= (tx_on || tx_busy) && !tx_val;
            serial_in_oe <= 1'b0;
        end
    end

    property p_off_flags;
        @(posedge hclk) disable iff (!hresetn)
        !on |=> txe && txd;
    endproperty
    a_off_flags: assert property (p_off_flags)
        else $error("Empty or done flag low while module off");

    property p_enable_lock;
        @(posedge hclk) disable iff (!hresetn)
        wr_ctl2 && !on |=> $stable(tx_on) && $stable(rx_on);
    endproperty
    a_enable_lock: assert property (p_enable_lock)
        else $error("Direction enable changed while module off");

    property p_rx_input;
        @(posedge hclk) disable iff (!hresetn)
        on |=> !serial_in_oe;
    endproperty
    a_rx_input: assert property (p_rx_input)
        else $error("Receive pin driven while module on");

    property p_port_ctl;
        @(posedge hclk) disable iff (!hresetn)
        !on |=> serial_in_oe == $past(port7_drive);
    endproperty
    a_port_ctl: assert property (p_port_ctl)
        else $error("Receive pin not under port control");

    property p_fe_rxf;
        @(posedge hclk) disable iff (!hresetn)
        rx_done && !standby && rx_bad |=> fe && rxf;
    endproperty
    a_fe_rxf: assert property (p_fe_rxf)
        else $error("Framing error not set with receive full");

    property p_freeze;
        @(posedge hclk) disable iff (!hresetn)
        freeze && rxf |=> rxf;
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("Receive flag cleared during protected break");

    property p_stop_hold;
        @(posedge hclk) disable iff (!hresetn)
        stopped |=> $stable(tx_busy) && $stable(tx_line);
    endproperty
    a_stop_hold: assert property (p_stop_hold)
        else $error("Transmitter moved during stop mode");

    property p_wake;
        @(posedge hclk) disable iff (!hresetn)
        stopped && !wake_irq |=> stopped;
    endproperty
    a_wake: assert property (p_wake)
        else $error("Left stop mode without wake interrupt");

    property p_tx_release;
        @(posedge hclk) disable iff (!hresetn)
        on && !tx_on && !tx_busy |=> !serial_out_oe;
    endproperty
    a_tx_release: assert property (p_tx_release)
        else $error("Transmit pin driven after transmitter off");
endmodule // serial_port_top

/* File: testbench/remote_serial.sv */
// Far end of the serial link: captures bytes, sends 8-bit frames.
// Assumes idle-high wires and BIT_CLKS clocks per bit.
`timescale 1ns/1ps
module remote_serial #(
    parameter int BIT_CLKS = 16
)
(
    input wire logic hclk, // Module clock
    input wire logic tx_wire, // Transmit wire level
    output logic rx_line, // Level sent toward receiver
    output logic [7:0] got, // Last byte captured
    output int n_got // Bytes captured
);
    // Capture after a start edge, mid-bit, LSB first
    initial
    begin
        rx_line = 1'b1;
        got = 8'h00;
        n_got = 0;
        forever
        begin
            @(negedge tx_wire);
            repeat (BIT_CLKS / 2) @(posedge hclk);
            for (int i = 0; i < 8; i++)
            begin
                repeat (BIT_CLKS) @(posedge hclk);
                got[i] = tx_wire;
            end
            n_got++;
        end
    end
    // A zero stop bit makes a framing fault on purpose
    task automatic send(input logic [7:0] d, input logic stop_val);
        logic [9:0] f;
        f = {stop_val, d, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            rx_line <= f[i];
            repeat (BIT_CLKS) @(posedge hclk);
        end
        rx_line <= 1'b1;
    endtask
endmodule // remote_serial

/* File: testbench/serial_port_config_and_pins_test.sv */
// Self-checking bench: registers over AHB-Lite, pin modes, link traffic.
// Assumes a zero-wait slave and open-drain pins with pullups.
`timescale 1ns/1ps
module serial_port_config_and_pins_test;
    import serial_port_pkg::*;
    typedef struct packed {logic [7:0] a; logic [31:0] w, e;} row_t;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic stop_req = 1'b0, wake_irq = 1'b0, brk = 1'b0;
    logic dir6 = 1'b0, out6 = 1'b0, jam = 1'b0;
    logic hreadyout, hresp, tx_oe, rx_oe, rx_line, opin, idrv;
    logic [31:0] hrdata, rd;
    logic [7:0] got;
    int n_got, n0, k;
    int n_fail = 0;
    int cmp_count = 0;
    // Pullups lift each wire unless someone pulls it low
    wire tx_wire = tx_oe ? 1'b0 : 1'b1;
    wire rx_wire = (rx_oe | jam) ? 1'b0 : rx_line;
    row_t rows [8] = '{{OFS_CTL1, 32'h3f, 32'h3f}, {OFS_CTL2, 32'hc, 32'h0},
        {8'h18, 32'hff, 32'h0}, {OFS_CTL1, 32'h40, 32'h40},
        {OFS_CTL2, 32'hc, 32'hc}, {OFS_CTL2, 32'h0, 32'h0},
        {OFS_STAT, 32'h0, 32'h80}, {OFS_CTL1, 32'h0, 32'h0}};
    always #50 hclk = ~hclk;
    serial_port_top #(.BIT_CLKS(16)) serial_port_top_i (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .stop_req(stop_req), .wake_irq(wake_irq), .break_state(brk),
        .port_dir_bit6(dir6), .port_dir_bit7(dir6), .port_out6(out6),
        .port_out7(out6), .serial_in_pin(rx_wire), .serial_out_pin(opin),
        .serial_out_oe(tx_oe), .serial_in_drv(idrv), .serial_in_oe(rx_oe));
    remote_serial #(.BIT_CLKS(16)) remote_serial_i (.hclk(hclk),
        .tx_wire(tx_wire), .rx_line(rx_line), .got(got), .n_got(n_got));
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Single word transfer; each phase held until hready is seen high
    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // Polling status also arms the two-step flag clear
    task automatic wait_stat(input logic [7:0] m);
        k = 0;
        do
        begin
            bus(1'b0, OFS_STAT, 32'h0);
            k++;
        end
        while ((rd[7:0] & m) !== m && k < 400);
    endtask
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Watchdog at 20000 cycles; the tests need well under 8000 cycles
    initial
    begin
        #2ms;
        n_fail++;
        report_and_stop();
    end
    initial
    begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, OFS_CTL1, 32'h0);
        check(rd, 32'h0);
        foreach (rows[i])
        begin
            bus(1'b1, rows[i].a, rows[i].w);
            bus(1'b0, rows[i].a, 32'h0);
            check(rd, rows[i].e);
        end
        dir6 <= 1'b1;
        repeat (2) @(posedge hclk);
        check({30'h0, tx_oe, rx_oe}, 32'h3);
        bus(1'b1, OFS_CTL1, 32'h40);
        repeat (2) @(posedge hclk);
        check({30'h0, tx_oe, rx_oe}, 32'h0);
        check({29'h0, hresp, opin, idrv}, 32'h0);
        dir6 <= 1'b0;
        bus(1'b1, OFS_CTL2, 32'h4);
        remote_serial_i.send(8'ha5, 1'b1);
        wait_stat(8'h20);
        bus(1'b0, OFS_DATA, 32'h0);
        check({24'h0, rd[7:0]}, 32'ha5);
        // Stop-bit fault, then a clear split across a break
        remote_serial_i.send(8'h3c, 1'b0);
        wait_stat(8'h22);
        check(rd & 32'h22, 32'h22);
        brk <= 1'b1;
        bus(1'b0, OFS_DATA, 32'h0);
        bus(1'b0, OFS_STAT, 32'h0);
        check(rd & 32'h22, 32'h22);
        brk <= 1'b0;
        bus(1'b0, OFS_DATA, 32'h0);
        bus(1'b0, OFS_STAT, 32'h0);
        check(rd & 32'h22, 32'h0);
        // Even then odd parity land in the top data bit
        for (int i = 0; i < 2; i++)
        begin
            bus(1'b1, OFS_CTL1, 32'h42 | i);
            bus(1'b1, OFS_CTL2, 32'hc);
            n0 = n_got;
            bus(1'b1, OFS_DATA, 32'h3);
            for (k = 0; k < 2000 && n_got == n0; k++) @(posedge hclk);
            check({24'h0, got}, i ? 32'h83 : 32'h03);
            // Let the frame end before parity or stop mode is touched
            repeat (32) @(posedge hclk);
        end
        stop_req <= 1'b1;
        bus(1'b1, OFS_CTL1, 32'hc0);
        stop_req <= 1'b0;
        bus(1'b0, OFS_CTL1, 32'h0);
        check(rd, 32'hc0);
        wake_irq <= 1'b1;
        @(posedge hclk);
        wake_irq <= 1'b0;
        // Loop must ignore a jammed receive pin
        jam <= 1'b1;
        bus(1'b1, OFS_DATA, 32'h5a);
        wait_stat(8'h20);
        // With permission, a clear made inside a break must stick
        bus(1'b1, OFS_BRKC, 32'h1);
        brk <= 1'b1;
        bus(1'b0, OFS_DATA, 32'h0);
        check({24'h0, rd[7:0]}, 32'h5a);
        brk <= 1'b0;
        bus(1'b0, OFS_STAT, 32'h0);
        check(rd & 32'h20, 32'h0);
        report_and_stop();
    end
endmodule // serial_port_config_and_pins_test
